// ---- verilog/ebpfm_defines.svh ----
`ifndef EBPFM_DEFINES_SVH
`define EBPFM_DEFINES_SVH
// ==========================================================
// register offsets
`define EBPFM_OFS_LATCH 16'hFE44
`define EBPFM_OFS_DIR 16'hFE45
`define EBPFM_OFS_FUNC 16'hFE46
// ==========================================================
// reset values
`define EBPFM_RST_LATCH 8'h00
`define EBPFM_RST_DIR 8'h00
`define EBPFM_RST_FUNC 8'h00
// ==========================================================
// field positions of the muxed pins
`define EBPFM_BIT_TIMER_PULSE_HIGH_OUT 7
`define EBPFM_BIT_TIMER_PULSE_LOW_OUT 6
`define EBPFM_BIT_SCK1 5
`define EBPFM_BIT_SO1A 4
`define EBPFM_BIT_SO1B 3
`define EBPFM_BIT_SCK0 2
`define EBPFM_BIT_SO0A 1
`define EBPFM_BIT_SO0B 0
`define EBPFM_BIT_SI1 4
`define EBPFM_BIT_SI0 1
`endif

// ---- verilog/ebpfm_pkg.sv ----
`default_nettype none
// ==========================================================
// shared types
package ebpfm_pkg;
  // on-chip sources that may be routed onto the pins
  typedef struct packed {
    logic pwm_high;
    logic pwm_low;
    logic buzzer;
    logic ser0_clk;
    logic ser0_data;
    logic ser1_clk;
    logic ser1_data;
  } ebpfm_func_src_t;
  // per-pin drive: output enable, output level, pull-up enable
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] pu;
  } ebpfm_pin_drv_t;
  // standby state of the port
  typedef enum logic {EBPFM_RUN, EBPFM_HOLD} ebpfm_mode_t;
endpackage : ebpfm_pkg
`default_nettype wire

// ---- verilog/ebpfm_port.sv ----
// How it works
// - a plain read of the latch address returns the pin levels, not the latch.
// - a read-modify-write read of the latch address returns the stored latch value.
// - pin levels are readable whatever the direction of each pin.
// - a direction bit of 1 makes its pin an output and 0 makes it an input.
// - the pull-up is on only when direction is 0 and latch is 1, else off.
// - an output from the latch drives low for 0 and high or released for 1.
// - bit 7 in function mode drives latch xor (pwm high and buzzer).
// - bit 6 in function mode drives pwm low xor latch.
// - bit 5 in function mode drives second serial clock or latch.
// - bits 4 and 3 in function mode drive second serial data or latch.
// - bit 2 in function mode drives first serial clock or latch.
// - bits 1 and 0 in function mode drive first serial data or latch.
// - the second serial unit receives from the bit 4 pin while it runs.
// - the first serial unit receives from the bit 1 pin while it runs.
// - open-drain pins show a high level as a released pin.
// - in standby every pin holds its state from standby entry.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ebpfm_defines.svh"
module ebpfm_port
  import ebpfm_pkg::*;
#(
  parameter logic [7:0] OPEN_DRAIN = 8'h00
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rmw,
  output logic [7:0] reg_rdata,
  // standby request
  input wire logic standby,
  // on-chip function sources
  input wire ebpfm_func_src_t func_src,
  input wire logic ser0_active,
  input wire logic ser1_active,
  output logic ser0_rx,
  output logic ser1_rx,
  // pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pu
);
  // ========================================================
  // registers
  logic [7:0] latch_q, latch_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] func_q, func_d;
  logic [7:0] rdata_d;
  ebpfm_pin_drv_t drv_q, drv_d, drv_calc;
  ebpfm_mode_t mode_q, mode_d;
  logic [7:0] fval;

  // address decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic hit_latch = hit(reg_addr, `EBPFM_OFS_LATCH);
  wire logic hit_dir = hit(reg_addr, `EBPFM_OFS_DIR);
  wire logic hit_func = hit(reg_addr, `EBPFM_OFS_FUNC);

  // register writes
  assign latch_d = (reg_wr && hit_latch) ? reg_wdata : latch_q;
  assign dir_d = (reg_wr && hit_dir) ? reg_wdata : dir_q;
  assign func_d = (reg_wr && hit_func) ? reg_wdata : func_q;

  // read mux: pins on plain read, latch on rmw read
  // rmw reads must see the latch, or a bit set on an input pin
  // would be written back with whatever level the line shows
  // idle cycles return zero so a stale value never lingers
  wire logic [7:0] latch_view = reg_rmw ? latch_q : pin_i;
  assign rdata_d = !reg_rd ? 8'h00 :
                   hit_latch ? latch_view :
                   hit_dir ? dir_q :
                   hit_func ? func_q : 8'h00;

  // ========================================================
  // function mux values per bit
  wire logic pwm_mix = func_src.pwm_high & func_src.buzzer;
  assign fval[`EBPFM_BIT_TIMER_PULSE_HIGH_OUT] = latch_q[`EBPFM_BIT_TIMER_PULSE_HIGH_OUT] ^ pwm_mix;
  assign fval[`EBPFM_BIT_TIMER_PULSE_LOW_OUT] = func_src.pwm_low ^ latch_q[`EBPFM_BIT_TIMER_PULSE_LOW_OUT];
  assign fval[`EBPFM_BIT_SCK1] = func_src.ser1_clk | latch_q[`EBPFM_BIT_SCK1];
  assign fval[`EBPFM_BIT_SO1A] = func_src.ser1_data | latch_q[`EBPFM_BIT_SO1A];
  assign fval[`EBPFM_BIT_SO1B] = func_src.ser1_data | latch_q[`EBPFM_BIT_SO1B];
  assign fval[`EBPFM_BIT_SCK0] = func_src.ser0_clk | latch_q[`EBPFM_BIT_SCK0];
  assign fval[`EBPFM_BIT_SO0A] = func_src.ser0_data | latch_q[`EBPFM_BIT_SO0A];
  assign fval[`EBPFM_BIT_SO0B] = func_src.ser0_data | latch_q[`EBPFM_BIT_SO0B];

  // per-pin drive calculation
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      // level wanted on an output pin; function bit ignored for inputs
      wire logic lvl = func_q[g] ? fval[g] : latch_q[g];
      // open drain releases on high
      assign drv_calc.oe[g] = dir_q[g] & ~(OPEN_DRAIN[g] & lvl);
      assign drv_calc.out[g] = dir_q[g] & lvl;
      assign drv_calc.pu[g] = ~dir_q[g] & latch_q[g];
    end
  endgenerate

  // standby holds the pins frozen
  // registers still accept writes; only the pin drive is held
  assign mode_d = standby ? EBPFM_HOLD : EBPFM_RUN;
  assign drv_d = standby ? drv_q : drv_calc;

  // ========================================================
  // state flops
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      latch_q <= `EBPFM_RST_LATCH;
      dir_q <= `EBPFM_RST_DIR;
      func_q <= `EBPFM_RST_FUNC;
      reg_rdata <= 8'h00;
      drv_q <= '0;
      mode_q <= EBPFM_RUN;
    end else begin
      latch_q <= latch_d;
      dir_q <= dir_d;
      func_q <= func_d;
      reg_rdata <= rdata_d;
      drv_q <= drv_d;
      mode_q <= mode_d;
    end
  end

  // serial receive path, taken from the pin in any direction
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ser0_rx <= 1'b0;
      ser1_rx <= 1'b0;
    end else begin
      ser1_rx <= ser1_active ? pin_i[`EBPFM_BIT_SI1] : 1'b0;
      ser0_rx <= ser0_active ? pin_i[`EBPFM_BIT_SI0] : 1'b0;
    end
  end

  // pin outputs straight from flops
  assign pin_o = drv_q.out;
  assign pin_oe = drv_q.oe;
  assign pin_pu = drv_q.pu;

  // ========================================================
  // assertions
  a_plain_read_pins: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && hit_latch && !reg_rmw |=> reg_rdata == $past(pin_i))
    else $error("plain latch read did not return pins");
  a_rmw_read_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && hit_latch && reg_rmw |=> reg_rdata == $past(latch_q))
    else $error("rmw read did not return latch");
  a_read_any_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && hit_latch && !reg_rmw && dir_q == 8'hFF |=> reg_rdata == $past(pin_i))
    else $error("pins not readable as outputs");
  a_input_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && !$past(standby) && $past(dir_q) == 8'h00 |-> pin_oe == 8'h00)
    else $error("input pin driven");
  a_pullup_rule: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby |=> pin_pu == ($past(~dir_q & latch_q)))
    else $error("pull-up wrong");
  a_low_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[0] && !func_q[0] && !latch_q[0] |=> pin_oe[0] && !pin_o[0])
    else $error("output low not driven");
  a_pwm_high_mux: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[7] && func_q[7] |=>
      pin_o[7] == $past(latch_q[7] ^ (func_src.pwm_high & func_src.buzzer)))
    else $error("bit 7 mux wrong");
  a_pwm_low_mux: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[6] && func_q[6] |=>
      pin_o[6] == $past(func_src.pwm_low ^ latch_q[6]))
    else $error("bit 6 mux wrong");
  a_ser1_clk_mux: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[5] && func_q[5] |=>
      pin_o[5] == $past(func_src.ser1_clk | latch_q[5]))
    else $error("bit 5 mux wrong");
  a_ser1_data_mux: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[4] && func_q[4] |=>
      pin_o[4] == $past(func_src.ser1_data | latch_q[4]))
    else $error("bit 4 mux wrong");
  a_ser0_clk_mux: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[2] && func_q[2] |=>
      pin_o[2] == $past(func_src.ser0_clk | latch_q[2]))
    else $error("bit 2 mux wrong");
  a_ser0_data_mux: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[0] && func_q[0] |=>
      pin_o[0] == $past(func_src.ser0_data | latch_q[0]))
    else $error("bit 0 mux wrong");
  a_ser1_rx_path: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ser1_active |=> ser1_rx == $past(pin_i[4]))
    else $error("second serial rx wrong");
  a_ser0_rx_path: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ser0_active |=> ser0_rx == $past(pin_i[1]))
    else $error("first serial rx wrong");
  a_od_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pin_o & OPEN_DRAIN & pin_oe) == 8'h00)
    else $error("open drain drove high");
  a_standby_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    standby |=> $stable(pin_o) && $stable(pin_oe) && $stable(pin_pu))
    else $error("pins moved in standby");
  a_func_ignored_in: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && !dir_q[7] |=> !pin_oe[7] && pin_pu[7] == $past(latch_q[7]))
    else $error("function bit affected input");
  // ========================================================
  // assertions on the second pins of shared functions and on bit 0 driving high
  a_ser1_data_b3: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[3] && func_q[3] |=>
      pin_o[3] == $past(func_src.ser1_data | latch_q[3]))
    else $error("bit 3 mux wrong");
  a_ser0_data_b1: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[1] && func_q[1] |=>
      pin_o[1] == $past(func_src.ser0_data | latch_q[1]))
    else $error("bit 1 mux wrong");
  a_high_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby && dir_q[0] && !func_q[0] && latch_q[0] |=> pin_o[0])
    else $error("output high not driven");

  // ========================================================
  // assertions on drive, pull-up, output type and the recorded standby state
  a_pp_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby |=> (pin_oe & ~OPEN_DRAIN) == ($past(dir_q) & ~OPEN_DRAIN))
    else $error("push-pull output not enabled");
  a_input_out_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby |=> (pin_o & ~$past(dir_q)) == 8'h00)
    else $error("input pin shows a level");
  a_pu_off_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !standby |=> (pin_pu & $past(dir_q)) == 8'h00)
    else $error("pull-up on an output");
  a_reset_clear: assert property (@(posedge clk_sys)
    !rst_b |=> pin_oe == 8'h00 && pin_o == 8'h00 && pin_pu == 8'h00)
    else $error("pins not cleared by reset");
  a_mode_tracks: assert property (@(posedge clk_sys) disable iff (!rst_b)
    standby |=> mode_q == EBPFM_HOLD)
    else $error("standby state not recorded");

  // ========================================================
  // assertions on the register port
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without a read");
  a_dir_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && hit_dir |=> reg_rdata == $past(dir_q))
    else $error("direction read wrong");
  a_func_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && hit_func |=> reg_rdata == $past(func_q))
    else $error("function read wrong");
  a_latch_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && hit_latch |=> latch_q == $past(reg_wdata))
    else $error("latch write lost");
  a_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && hit_dir |=> dir_q == $past(reg_wdata))
    else $error("direction write lost");
  a_func_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && hit_func |=> func_q == $past(reg_wdata))
    else $error("function write lost");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(reg_wr && hit_latch) |=> $stable(latch_q))
    else $error("latch changed without write");
  a_dir_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(reg_wr && hit_dir) |=> $stable(dir_q))
    else $error("direction changed without write");
  a_func_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(reg_wr && hit_func) |=> $stable(func_q))
    else $error("function changed without write");

  // ========================================================
  // assertions on the receive paths when idle
  a_rx0_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ser0_active |=> !ser0_rx)
    else $error("first serial rx not idle");
  a_rx1_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ser1_active |=> !ser1_rx)
    else $error("second serial rx not idle");

  // per-pin check that inputs ignore the function bit
  generate
    for (g = 0; g < 8; g++) begin : g_chk
      a_func_ignored_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !standby && !dir_q[g] |=> !pin_oe[g] && pin_pu[g] == $past(latch_q[g]))
        else $error("function bit affected an input pin");
    end
  endgenerate

  // ========================================================
  // cover points for the main scenarios
  c_plain_read: cover property (@(posedge clk_sys) reg_rd && hit_latch && !reg_rmw);
  c_od_release: cover property (@(posedge clk_sys) (pin_o & OPEN_DRAIN & ~pin_oe) != 8'h00);
  c_rmw_read: cover property (@(posedge clk_sys) reg_rd && hit_latch && reg_rmw);
  c_func_out: cover property (@(posedge clk_sys) dir_q[7] && func_q[7]);
  c_standby: cover property (@(posedge clk_sys) standby ##1 !standby);
endmodule : ebpfm_port
`default_nettype wire

// ---- sim/ebpfm_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external pin model
module ebpfm_pins (
  // clock
  input wire logic clk_sys,
  // port drive
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pu,
  // outside driver
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved levels
  output logic [7:0] pin_i
);
  logic [7:0] last_q = 8'h00;
  // port drive wins, then outside, then pull-up, else a floating line toggles
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & (pin_pu | ~last_q));
  // last level, so a floating line never holds its value
  always_ff @(posedge clk_sys) begin
    last_q <= pin_i;
  end
endmodule : ebpfm_pins
`default_nettype wire

// ---- sim/ebpfm_port_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench for the port
module ebpfm_port_bench;
  import ebpfm_pkg::*;
  logic clk_sys, rst_b, reg_wr, reg_rd, reg_rmw, standby, ser0_active, ser1_active;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, ext_val, ext_en, d, l;
  ebpfm_func_src_t func_src;
  wire logic [7:0] reg_rdata, pin_i, pin_o, pin_oe, pin_pu;
  wire logic ser0_rx, ser1_rx;
  int bad_count = 0;
  int n_checks = 0;
  ebpfm_port #(.OPEN_DRAIN(8'h08)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw),
    .reg_rdata(reg_rdata), .standby(standby), .func_src(func_src),
    .ser0_active(ser0_active), .ser1_active(ser1_active), .ser0_rx(ser0_rx),
    .ser1_rx(ser1_rx), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu));
  ebpfm_pins pins (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu),
    .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // bus cycles and compare
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic m, output logic [7:0] v);
    @(posedge clk_sys) begin reg_rd <= 1'b1; reg_rmw <= m; reg_addr <= a; end
    @(posedge clk_sys) begin reg_rd <= 1'b0; reg_rmw <= 1'b0; end
    #1 v = reg_rdata;
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // pin level expected in function mode
  function automatic logic [7:0] fx(input logic [7:0] q, input ebpfm_func_src_t s);
    return {q[7] ^ (s.pwm_high & s.buzzer), s.pwm_low ^ q[6], s.ser1_clk | q[5],
      s.ser1_data | q[4], s.ser1_data | q[3], s.ser0_clk | q[2], s.ser0_data | q[1],
      s.ser0_data | q[0]};
  endfunction : fx
  // watchdog
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  // main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, reg_rmw, standby, ser0_active, ser1_active} = '0;
    reg_addr = 16'h0000; reg_wdata = 8'h00; func_src = '0;
    ext_val = 8'hA5; ext_en = 8'hFF;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(16'hFE45, 1'b0, d); chk("dir", d, 8'h00);
    rd(16'hFE46, 1'b0, d); chk("func", d, 8'h00);
    rd(16'hFE44, 1'b0, d); chk("pins", d, 8'hA5);
    rd(16'hFE44, 1'b1, d); chk("latch", d, 8'h00);
    rd(16'hFE47, 1'b0, d); chk("unmapped", d, 8'h00);
    $display("test reset done");
    wr(16'hFE44, 8'h3C); wr(16'hFE46, 8'hFF); settle();
    chk("pu", pin_pu, 8'h3C);
    chk("oe", pin_oe, 8'h00);
    rd(16'hFE44, 1'b1, d); chk("latch", d, 8'h3C);
    @(posedge clk_sys) ext_en <= 8'h0F;
    wr(16'hFE45, 8'hF0); settle();
    chk("oe", pin_oe, 8'hF0);
    chk("out", pin_o & 8'hF0, fx(8'h3C, '0) & 8'hF0);
    chk("pu", pin_pu, 8'h0C);
    rd(16'hFE44, 1'b0, d); chk("pins", d, 8'h35);
    @(posedge clk_sys) ext_en <= 8'h00;
    wr(16'hFE45, 8'hFF); wr(16'hFE46, 8'h00); wr(16'hFE44, 8'h5A);
    settle(); chk("out", pin_o, 8'h5A);
    chk("oe", pin_oe, 8'hF7);
    chk("pu", pin_pu, 8'h00);
    $display("test direction done");
    wr(16'hFE46, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      l = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'h5A;
      wr(16'hFE44, l);
      for (int k = 0; k < 128; k++) begin
        @(posedge clk_sys) func_src <= 7'(k);
        settle(); chk("mux", pin_o, fx(l, 7'(k)));
      end
    end
    $display("test function done");
    @(posedge clk_sys) begin ser0_active <= 1'b1; ser1_active <= 1'b1; func_src <= '0; end
    wr(16'hFE46, 8'h00); wr(16'hFE44, 8'h12); settle();
    chk("rx", {6'h00, ser1_rx, ser0_rx}, 8'h03);
    wr(16'hFE44, 8'h00); settle();
    chk("rx", {6'h00, ser1_rx, ser0_rx}, 8'h00);
    $display("test serial done");
    @(posedge clk_sys) standby <= 1'b1;
    @(posedge clk_sys);
    wr(16'hFE44, 8'hFF); settle(); chk("hold", pin_o, 8'h00);
    @(posedge clk_sys) standby <= 1'b0;
    settle(); chk("out", pin_o, 8'hFF);
    $display("test standby done");
    @(posedge clk_sys) rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1 chk("oe", pin_oe, 8'h00);
    rd(16'hFE44, 1'b1, d); chk("latch", d, 8'h00);
    rd(16'hFE45, 1'b0, d); chk("dir", d, 8'h00);
    $display("test second reset done");
    test_done();
  end
endmodule : ebpfm_port_bench
`default_nettype wire
